// ---- verif/meor_host_model.sv ----
// serial master model standing in for the host processor
`timescale 1ns/1ps
module meor_host_model (
    input wire clk,
    input wire spi_miso,
    input wire spi_miso_oe,
    output reg spi_sclk,
    output reg spi_cs_n,
    output reg spi_mosi
);
    reg last = 1'b0;
    // a released line toggles each cycle so a stale bit never reads as valid
    wire line = spi_miso_oe ? spi_miso : ~last;
    initial begin
        spi_sclk = 1'b1;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    always @(posedge clk) begin
        last <= line;
    end
    task wt(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // mode 3, msb first, four clocks a phase: four times the slave's one-clock minimum
    task frame(input [15:0] tx, input keep, output [15:0] rx);
        integer i;
        begin
            wt(1);
            spi_cs_n = 1'b0;
            wt(3);
            for (i = 15; i >= 0; i = i - 1) begin
                spi_sclk = 1'b0;
                spi_mosi = tx[i];
                wt(4);
                spi_sclk = 1'b1;
                rx[i] = line;
                wt(4);
            end
            if (!keep) begin
                spi_cs_n = 1'b1;
                wt(3);
            end
        end
    endtask
endmodule // meor_host_model

// ---- verif/meor_output_regs_chk.sv ----
// port checker for the result register block
`timescale 1ns/1ps
module meor_output_regs_chk #(
    parameter [31:0] SAMPLE_CYCLES = 32'h00000190
) (
    input wire clk,
    input wire rst_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_miso,
    input wire spi_miso_oe,
    input wire sample_done
);
    reg [31:0] gap;
    reg seen;
    // clocks since the last load pulse
    always @(posedge clk) begin
        if (!rst_n) begin
            gap <= 32'h00000000;
            seen <= 1'b0;
        end else begin
            gap <= sample_done ? 32'h00000000 : gap + 32'h00000001;
            seen <= seen | sample_done;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    oe_follows_cs_a: assert property (spi_miso_oe == !$past(spi_cs_n))
        else $error("output enable does not follow select");
    oe_release_a: assert property ($rose(spi_cs_n) |=> !spi_miso_oe)
        else $error("output enable still high after deselect");
    done_pulse_a: assert property (sample_done |=> !sample_done)
        else $error("load pulse longer than one cycle");
    period_exact_a: assert property (sample_done && seen |-> gap == SAMPLE_CYCLES - 32'h00000001)
        else $error("sample period wrong");
    period_min_a: assert property (sample_done |-> gap >= SAMPLE_CYCLES - 32'h00000002)
        else $error("sample load too early");
    period_max_a: assert property (gap <= SAMPLE_CYCLES + 32'h00000001)
        else $error("sample load missing");
    // a bit must stay put once the clock has been high for four samples in a row
    miso_holds_a: assert property (spi_sclk && $past(spi_sclk) && $past(spi_sclk, 2) && $past(spi_sclk, 3)
        && !spi_cs_n && !$past(spi_cs_n, 3) |-> $stable(spi_miso))
        else $error("data out moved while clock high");
    reset_clears_a: assert property (disable iff (1'b0) !rst_n |=> !spi_miso_oe && !sample_done && !spi_miso)
        else $error("outputs not cleared by reset");
endmodule // meor_output_regs_chk
bind meor_output_regs meor_output_regs_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) meor_output_regs_chk_i (.clk(clk),
    .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .sample_done(sample_done));

// ---- verif/test_meor_output_regs.sv ----
// self-checking bench for the result register block
`timescale 1ns/1ps
module test_meor_output_regs;
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg [15:0] diag = 16'h0000;
    reg [13:0] cv [0:8];
    reg [125:0] tab [0:2];
    wire sclk, cs_n, mosi, miso, oe, done;
    integer num_errors = 0;
    integer checked = 0;
    integer i;
    always #5 clk = ~clk;
    meor_output_regs #(.SAMPLE_CYCLES(32'h00000190)) meor_output_regs_i (.clk(clk), .rst_n(rst_n),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe),
        .accel_x_data(cv[0]), .accel_y_data(cv[1]), .accel_z_data(cv[2]), .magfield_x_data(cv[3]),
        .magfield_y_data(cv[4]), .magfield_z_data(cv[5]), .pressure_high_data(cv[6]),
        .pressure_low_data(cv[7][7:0]), .die_temperature_data(cv[8][11:0]), .diagnostic_status(diag),
        .sample_done(done));
    meor_host_model meor_host_model_i (.clk(clk), .spi_miso(miso), .spi_miso_oe(oe), .spi_sclk(sclk),
        .spi_cs_n(cs_n), .spi_mosi(mosi));
    task wt(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    task check(input [23:0] seen, input [23:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d mismatches %0d", checked, num_errors);
            if (num_errors == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wait_sample;
        begin
            i = 0;
            while (done !== 1'b1 && i < 1000) begin
                wt(1);
                i = i + 1;
            end
            check(done, 1'b1);
        end
    endtask
    task load_set(input integer s, input [15:0] d);
        integer k;
        begin
            diag = d;
            for (k = 0; k < 9; k = k + 1)
                cv[k] = tab[s][125 - 14 * k -: 14];
            wt(2);
            wait_sample;
        end
    endtask
    function [15:0] expw(input integer k, input [13:0] c, input e);
        expw = (k == 7) ? {8'h00, c[7:0]} : (k == 8) ? {1'b1, e, 2'b00, c[11:0]} : {1'b1, e, c};
    endfunction
    task t_sweep(input integer s, input [15:0] d);
        reg [15:0] rx, tx, hi, lo;
        integer k;
        begin
            load_set(s, d);
            tx = 16'h0A00;
            meor_host_model_i.frame(tx, 1'b0, rx);
            for (k = 0; k < 9; k = k + 1) begin
                tx = tx + 16'h0200;
                meor_host_model_i.frame(tx, 1'b0, rx);
                check(rx, expw(k, cv[k], d != 16'h0000));
                if (k == 6)
                    hi = rx;
                if (k == 7)
                    lo = rx;
            end
            check({2'b00, hi[13:0], 8'h00} + lo[7:0], {2'b00, cv[6], cv[7][7:0]});
            $display("sweep %0d done", s);
        end
    endtask
    task t_fresh;
        reg [15:0] rx;
        begin
            wait_sample;
            meor_host_model_i.frame(16'h0A00, 1'b0, rx);
            meor_host_model_i.frame(16'h0A00, 1'b0, rx);
            check(rx[15], 1'b1);
            meor_host_model_i.frame(16'h0000, 1'b0, rx);
            check(rx[15], 1'b0);
            wait_sample;
            meor_host_model_i.frame(16'h0A00, 1'b0, rx);
            meor_host_model_i.frame(16'h0000, 1'b0, rx);
            check(rx[15], 1'b1);
            $display("fresh flag test done");
        end
    endtask
    task t_refuse;
        reg [15:0] rx;
        begin
            meor_host_model_i.frame(16'h8A55, 1'b0, rx);
            meor_host_model_i.frame(16'h0B00, 1'b0, rx);
            check(rx, 16'h0000);
            meor_host_model_i.frame(16'h1C00, 1'b0, rx);
            check(rx, 16'h0000);
            meor_host_model_i.frame(16'h0A00, 1'b0, rx);
            check(rx, 16'h0000);
            meor_host_model_i.frame(16'h0000, 1'b0, rx);
            check(rx[13:0], cv[0]);
            $display("refusal test done");
        end
    endtask
    task t_burst;
        reg [15:0] rx;
        integer k;
        begin
            load_set(2, 16'h0000);
            meor_host_model_i.frame(16'h3E00, 1'b1, rx);
            // fresh bit masked: it depends on when the burst fetches each word
            for (k = 0; k < 10; k = k + 1) begin
                meor_host_model_i.frame(16'h0000, k < 9, rx);
                check(rx & 16'h7FFF, k < 9 ? expw(k, cv[k], 1'b0) & 16'h7FFF : 16'h0000);
            end
            $display("burst test done");
        end
    endtask
    initial begin
        tab[0] = {14'h1519, 14'h2AE7, 14'h3FFF, 14'h1388, 14'h2C78, 14'h3FFF, 14'h35B6, 14'h00A5, 14'h0E22};
        tab[1] = {14'h2AE7, 14'h0001, 14'h3FFE, 14'h2C78, 14'h0002, 14'h1388, 14'h30D4, 14'h005A, 14'h0FFF};
        tab[2] = {14'h0002, 14'h1519, 14'h0000, 14'h3FFE, 14'h1388, 14'h0001, 14'h0001, 14'h00FF, 14'h024C};
        for (i = 0; i < 9; i = i + 1)
            cv[i] = 14'h0000;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_sweep(0, 16'h0000);
        t_fresh;
        t_refuse;
        t_sweep(1, 16'h0100);
        t_burst;
        summarize;
    end
    initial begin
        #600000;
        num_errors = num_errors + 1;
        summarize;
    end
endmodule // test_meor_output_regs

// ---- verilog/meor_map.vh ----
// constants for the motion and environment result register block
`ifndef MEOR_MAP_VH
`define MEOR_MAP_VH

// register addresses on the serial link
`define MEOR_ADDR_ACCEL_X 7'h0A
`define MEOR_ADDR_ACCEL_Y 7'h0C
`define MEOR_ADDR_ACCEL_Z 7'h0E
`define MEOR_ADDR_MAG_X 7'h10
`define MEOR_ADDR_MAG_Y 7'h12
`define MEOR_ADDR_MAG_Z 7'h14
`define MEOR_ADDR_PRESS_HIGH 7'h16
`define MEOR_ADDR_PRESS_LOW 7'h18
`define MEOR_ADDR_TEMP 7'h1A
`define MEOR_ADDR_FIRST `MEOR_ADDR_ACCEL_X
`define MEOR_ADDR_LAST `MEOR_ADDR_TEMP

// entry indices, in ascending address order
`define MEOR_NUM_REGS 4'h9
`define MEOR_IDX_PRESS_LOW 4'h7
`define MEOR_IDX_TEMP 4'h8

// result word fields
`define MEOR_FRESH_BIT 15
`define MEOR_ERR_BIT 14
`define MEOR_DATA_W 14
`define MEOR_PRESS_LOW_W 8
`define MEOR_TEMP_W 12

// serial frame layout
`define MEOR_FRAME_BITS 5'h10
`define MEOR_RW_BIT 15
`define MEOR_ADDR_MSB 14
`define MEOR_ADDR_LSB 8
`define MEOR_BURST_ADDR 7'h3E
`define MEOR_RESET_WORD 16'h0000

// sample timing: 819.2 samples per second, kept as tenths of a sample per second
`define MEOR_CLK_HZ 32'h05F5E100
`define MEOR_SAMPLE_RATE_DECI 32'h00002000
`define MEOR_SAMPLE_CYCLES ((`MEOR_CLK_HZ * 32'h0000000A) / `MEOR_SAMPLE_RATE_DECI)

`endif

// ---- verilog/meor_output_regs.v ----
// motion, magnetic, pressure and temperature result registers behind a mode 3 serial slave
//
// Contract
// [RQ1] bit 15 of each flagged result word is one while it holds an unread sample
// [RQ2] bit 14 of each flagged result word is one while any error or alarm is active
// [RQ3] acceleration words carry a 14-bit twos complement value in bits 13:0
// [RQ4] acceleration codes pass unchanged: full scale 0x1519, 0x2AE7, minus one 0x3FFF
// [RQ5] magnetic words carry a 14-bit twos complement field intensity in bits 13:0
// [RQ6] magnetic codes pass unchanged: 0x1388, 0x2C78 and 0x3FFF
// [RQ7] pressure high word carries unsigned 14-bit pressure in bits 13:0
// [RQ8] pressure low word carries unsigned 8-bit extension in bits 7:0, upper bits zero
// [RQ9] host joins high word shifted by eight with low byte for 22 bits
// [RQ10] pressure codes pass unchanged: 0x35B6, 0x30D4 and 0x0001
// [RQ11] temperature word carries 12-bit twos complement in bits 11:0, bits 13:12 zero
// [RQ12] temperature codes pass unchanged: 0x24C, 0x1B9, 0xFFF and 0xE22
// [RQ13] acceleration words are read-only at 0x0A, 0x0C and 0x0E
// [RQ14] magnetic words read-only at 0x10..0x14, pressure words at 0x16 and 0x18
// [RQ15] temperature word is read-only at 0x1A
// [RQ16] all results reload autonomously once per sample period, 819.2 per second
// [RQ17] a read takes two 16-bit frames: address first, register in the next
// [RQ18] command 0x3E00 shifts out every result register in ascending address order
// [RQ19] fresh flag clears when its register is read and sets at next sample
// [RQ20] error flag is the OR of all diagnostic status bits
`timescale 1ns/1ps
`include "meor_map.vh"

module meor_output_regs #(
    parameter [31:0] SAMPLE_CYCLES = `MEOR_SAMPLE_CYCLES
) (
    input wire clk,
    input wire rst_n,
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_mosi,
    output reg spi_miso,
    output reg spi_miso_oe,
    input wire [13:0] accel_x_data,
    input wire [13:0] accel_y_data,
    input wire [13:0] accel_z_data,
    input wire [13:0] magfield_x_data,
    input wire [13:0] magfield_y_data,
    input wire [13:0] magfield_z_data,
    input wire [13:0] pressure_high_data,
    input wire [7:0] pressure_low_data,
    input wire [11:0] die_temperature_data,
    input wire [15:0] diagnostic_status,
    output reg sample_done
);

    // link states: which word the next frame end loads
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SINGLE = 3'h2;
    localparam [2:0] ST_BURST = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // autonomous sample timer

    reg [31:0] sample_cnt;
    wire sample_tick;

    assign sample_tick = (sample_cnt == SAMPLE_CYCLES - 32'h00000001);

    always @(posedge clk) begin
        if (!rst_n) begin
            sample_cnt <= 32'h00000000;
            sample_done <= 1'b0;
        end else begin
            if (sample_tick) begin
                sample_cnt <= 32'h00000000; // [RQ16]
            end else begin
                sample_cnt <= sample_cnt + 32'h00000001;
            end
            sample_done <= sample_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // error flag shared by every flagged word

    reg err_active;

    always @(posedge clk) begin
        if (!rst_n) begin
            err_active <= 1'b0;
        end else begin
            err_active <= |diagnostic_status; // [RQ20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result storage, one entry per register in ascending address order

    wire [13:0] raw_data [0:8];
    reg [13:0] data_q [0:8];
    reg [8:0] fresh_sample_flag;
    wire [15:0] reg_word [0:8];
    reg read_clear;
    reg [3:0] read_idx;

    // narrower fields are zero-extended so unused bits read as zero
    assign raw_data[0] = accel_x_data; // [RQ3] [RQ4]
    assign raw_data[1] = accel_y_data; // [RQ3] [RQ4]
    assign raw_data[2] = accel_z_data; // [RQ3] [RQ4]
    assign raw_data[3] = magfield_x_data; // [RQ5] [RQ6]
    assign raw_data[4] = magfield_y_data; // [RQ5] [RQ6]
    assign raw_data[5] = magfield_z_data; // [RQ5] [RQ6]
    assign raw_data[6] = pressure_high_data; // [RQ7] [RQ10]
    assign raw_data[7] = {6'h00, pressure_low_data}; // [RQ8]
    assign raw_data[8] = {2'h0, die_temperature_data}; // [RQ11] [RQ12]

    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_entry
            always @(posedge clk) begin
                if (!rst_n) begin
                    data_q[gi] <= 14'h0000;
                    fresh_sample_flag[gi] <= 1'b0;
                end else begin
                    if (sample_tick) begin
                        data_q[gi] <= raw_data[gi]; // [RQ16]
                    end
                    // a sample landing on the read cycle keeps the flag set
                    if (sample_tick) begin
                        fresh_sample_flag[gi] <= 1'b1; // [RQ19]
                    end else if (read_clear && read_idx == gi) begin
                        fresh_sample_flag[gi] <= 1'b0; // [RQ19]
                    end
                end
            end

            if (gi == 7) begin : g_low
                assign reg_word[gi] = {8'h00, data_q[gi][7:0]}; // [RQ8] [RQ9]
            end else if (gi == 8) begin : g_temp
                assign reg_word[gi] = {fresh_sample_flag[gi], err_active, 2'h0,
                                       data_q[gi][11:0]}; // [RQ1] [RQ2] [RQ11]
            end else begin : g_full
                assign reg_word[gi] = {fresh_sample_flag[gi], err_active, data_q[gi]}; // [RQ1] [RQ2]
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // serial link sampling; pins are synchronous, so edges come from one delay stage

    reg sclk_q;
    reg cs_n_q;
    reg [15:0] rx_shift;
    reg [4:0] bit_cnt;
    reg [15:0] tx_word;
    reg [2:0] link_state;
    reg [3:0] burst_idx;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;
    wire frame_done;
    wire [15:0] rx_next;
    wire [6:0] rx_addr;
    wire [6:0] addr_off;
    wire addr_hit;
    wire [3:0] addr_idx;

    assign sclk_rise = spi_sclk & ~sclk_q & ~spi_cs_n;
    assign sclk_fall = ~spi_sclk & sclk_q & ~spi_cs_n;
    assign cs_fall = ~spi_cs_n & cs_n_q;
    assign frame_done = sclk_rise && (bit_cnt == `MEOR_FRAME_BITS - 5'h01);
    assign rx_next = {rx_shift[14:0], spi_mosi};
    assign rx_addr = rx_next[`MEOR_ADDR_MSB:`MEOR_ADDR_LSB];
    assign addr_off = rx_addr - `MEOR_ADDR_FIRST;
    // only even addresses 0x0A..0x1A map; anything else except the burst address 0x3E reads back zero
    assign addr_hit = ~rx_addr[0] && rx_addr >= `MEOR_ADDR_FIRST
                      && rx_addr <= `MEOR_ADDR_LAST; // [RQ13] [RQ14] [RQ15]
    assign addr_idx = addr_off[4:1];

    always @(posedge clk) begin
        if (!rst_n) begin
            sclk_q <= 1'b1;
            cs_n_q <= 1'b1;
            rx_shift <= `MEOR_RESET_WORD;
            bit_cnt <= 5'h00;
        end else begin
            sclk_q <= spi_sclk;
            cs_n_q <= spi_cs_n;
            if (spi_cs_n) begin
                bit_cnt <= 5'h00;
            end else if (sclk_rise) begin
                rx_shift <= rx_next;
                if (frame_done) begin
                    bit_cnt <= 5'h00; // [RQ17]
                end else begin
                    bit_cnt <= bit_cnt + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame decode: the word answered in the frame after the request

    always @(posedge clk) begin
        if (!rst_n) begin
            tx_word <= `MEOR_RESET_WORD;
            link_state <= ST_IDLE;
            burst_idx <= 4'h0;
            read_clear <= 1'b0;
            read_idx <= 4'h0;
        end else begin
            read_clear <= 1'b0;
            if (spi_cs_n) begin
                // a burst lives only while select stays low; a single read survives
                if (link_state == ST_BURST) begin
                    link_state <= ST_IDLE;
                end
            end else if (frame_done) begin
                case (link_state)
                    ST_BURST: begin
                        // host data is ignored during a burst
                        if (burst_idx < `MEOR_NUM_REGS) begin
                            tx_word <= reg_word[burst_idx]; // [RQ18]
                            read_clear <= 1'b1;
                            read_idx <= burst_idx;
                            burst_idx <= burst_idx + 4'h1;
                        end else begin
                            tx_word <= `MEOR_RESET_WORD;
                        end
                    end
                    ST_IDLE, ST_SINGLE: begin
                        if (rx_next[`MEOR_RW_BIT]) begin
                            // writes touch nothing here; the next frame returns zero
                            tx_word <= `MEOR_RESET_WORD; // [RQ13] [RQ14] [RQ15]
                            link_state <= ST_IDLE;
                        end else if (rx_addr == `MEOR_BURST_ADDR) begin
                            tx_word <= reg_word[0]; // [RQ18]
                            read_clear <= 1'b1;
                            read_idx <= 4'h0;
                            burst_idx <= 4'h1;
                            link_state <= ST_BURST;
                        end else if (addr_hit) begin
                            tx_word <= reg_word[addr_idx]; // [RQ17]
                            read_clear <= 1'b1;
                            read_idx <= addr_idx;
                            link_state <= ST_SINGLE;
                        end else begin
                            tx_word <= `MEOR_RESET_WORD;
                            link_state <= ST_SINGLE;
                        end
                    end
                    default: begin
                        link_state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // data out: bit 15 shows at select, each later bit moves on a falling edge

    always @(posedge clk) begin
        if (!rst_n) begin
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end else begin
            spi_miso_oe <= ~spi_cs_n;
            if (cs_fall) begin
                spi_miso <= tx_word[15];
            end else if (sclk_fall) begin
                spi_miso <= tx_word[~bit_cnt[3:0]]; // [RQ17] [RQ18]
            end
        end
    end

endmodule // meor_output_regs
